// ==== cpu_regs_pkg.sv ====
// package: system register numbers, widths and field layout of the cpu register file
package cpu_regs_pkg;
   localparam int unsigned DATA_W       = 32;
   localparam int unsigned GPR_COUNT    = 32;
   localparam int unsigned GPR_IDX_W    = 5;
   localparam int unsigned SYS_IDX_W    = 5;
   localparam int unsigned PC_VALID_W   = 26;
   localparam int unsigned CAUSE_HALF_W = 16;

   // general register indices
   localparam logic [4:0] ZERO_REG_IDX         = 5'h00;
   localparam logic [4:0] ELEMENT_BASE_PTR_IDX = 5'h1e;

   // system register numbers
   localparam logic [4:0] SR_IRQ_SAVED_PC       = 5'h00;
   localparam logic [4:0] SR_IRQ_SAVED_STATUS   = 5'h01;
   localparam logic [4:0] SR_NMI_SAVED_PC       = 5'h02;
   localparam logic [4:0] SR_NMI_SAVED_STATUS   = 5'h03;
   localparam logic [4:0] SR_EXCEPTION_CAUSE    = 5'h04;
   localparam logic [4:0] SR_PROGRAM_STATUS     = 5'h05;
   localparam logic [4:0] SR_TCALL_SAVED_PC     = 5'h10;
   localparam logic [4:0] SR_TCALL_SAVED_STATUS = 5'h11;
   localparam logic [4:0] SR_TRAP_SAVED_PC      = 5'h12;
   localparam logic [4:0] SR_TRAP_SAVED_STATUS  = 5'h13;
   localparam logic [4:0] SR_TABLE_CALL_BASE    = 5'h14;

   // reset values
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam logic [31:0] PC_RESET  = 32'h0000_0000;

   // pc masks: 26 valid bits, bit 0 fixed at zero
   localparam logic [31:0] PC_MASK = 32'h03ff_fffe;
endpackage

// ==== gpr_if.sv ====
// interface: ports of the general register bank between the top and its memory
`timescale 1ns/10ps
interface gpr_if;
   logic [4:0]  ra_addr;
   logic [31:0] ra_data;
   logic [4:0]  rb_addr;
   logic [31:0] rb_data;
   logic        wr_en;
   logic [4:0]  wr_addr;
   logic [31:0] wr_data;
   modport owner (output ra_addr, input ra_data, output rb_addr, input rb_data,
                  output wr_en, output wr_addr, output wr_data);
   modport mem   (input ra_addr, output ra_data, input rb_addr, output rb_data,
                  input wr_en, input wr_addr, input wr_data);
endinterface

// ==== gpr_bank.sv ====
// file: two-read one-write general register memory with registered read data
`timescale 1ns/10ps
module gpr_bank
   import cpu_regs_pkg::*;
#(
   parameter int unsigned DEPTH = GPR_COUNT
) (
   input  wire logic clock,   // core clock
   input  wire logic sys_rst, // async reset, high
   gpr_if.mem        bus      // read and write ports
);
   logic [31:0] mem_q [DEPTH];
   logic [31:0] ra_q;
   logic [31:0] rb_q;

   // ==========================================================
   // storage; index zero stays zero since writes to it are dropped
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= REG_RESET;
         end
         ra_q <= REG_RESET;
         rb_q <= REG_RESET;
      end else begin
         if (bus.wr_en && bus.wr_addr != ZERO_REG_IDX) begin // RL18
            mem_q[bus.wr_addr] <= bus.wr_data;
         end
         // read returns old contents on same-cycle write
         ra_q <= (bus.ra_addr == ZERO_REG_IDX) ? REG_RESET : mem_q[bus.ra_addr]; // RL2
         rb_q <= (bus.rb_addr == ZERO_REG_IDX) ? REG_RESET : mem_q[bus.rb_addr]; // RL2
      end
   end

   assign bus.ra_data = ra_q;
   assign bus.rb_data = rb_q;
endmodule // gpr_bank

// ==== cpu_register_file.sv ====
// file: architectural register file of the core: general registers, pc, system registers
//
// Notes on behaviour
// (RL1) thirty-two general registers, index 0 to 31, data or address use.
// (RL2) general register zero always reads zero.
// (RL3) short load/store use general register thirty as base pointer.
// (RL4) pc keeps twenty-six valid bits; upper bits read zero.
// (RL5) carry from pc bit 25 into bit 26 is dropped.
// (RL6) pc bit zero is always zero.
// (RL7) system registers selected by number in load/store system instructions.
// (RL8) exception or maskable interrupt saves pc and status into sysregs 0 and 1.
// (RL9) non-maskable interrupt saves pc and status into sysregs 2 and 3.
// (RL10) cause register 4: nmi code high half, irq code low; not writable.
// (RL11) sysreg 5 holds the program status word, read and write.
// (RL12) table call saves pc and status into sysregs 16 and 17.
// (RL13) illegal-instruction trap saves pc, status into 18, 19; read only.
// (RL14) sysreg 20 holds the table call base, read and write.
// (RL15) software must not touch sysregs 6 to 15 or 21 to 31.
// (RL16) every register is 32 bits wide.
// (RL17) bit zero of saved pc values is ignored on return.
// (RL18) writes to general register zero are silently discarded.
`timescale 1ns/10ps
module cpu_register_file
   import cpu_regs_pkg::*;
(
   input  wire logic        clock,           // core clock, 100 MHz
   input  wire logic        sys_rst,         // async reset, active high
   // general register ports
   input  wire logic [4:0]  gpr_ra_addr,     // read port a index
   input  wire logic [4:0]  gpr_rb_addr,     // read port b index
   input  wire logic        short_mem_sel,   // short load/store: port a reads base
   output logic      [31:0] gpr_ra_data,     // read port a data, next cycle
   output logic      [31:0] gpr_rb_data,     // read port b data, next cycle
   input  wire logic        gpr_wr_en,       // general register write
   input  wire logic [4:0]  gpr_wr_addr,     // write index
   input  wire logic [31:0] gpr_wr_data,     // write data
   // program counter
   input  wire logic        pc_load,         // load pc from pc_target
   input  wire logic [31:0] pc_target,       // branch or vector address
   input  wire logic        pc_step,         // advance pc by pc_step_size
   input  wire logic [2:0]  pc_step_size,    // instruction length in bytes
   input  wire logic        ret_irq,         // return through irq saved pc
   input  wire logic        ret_nmi,         // return through nmi saved pc
   input  wire logic        ret_tcall,       // return through table call saved pc
   output logic      [31:0] pc,              // program counter
   // system register access
   input  wire logic        sysreg_load_instr,  // write sysreg from sr_wr_data
   input  wire logic        sysreg_store_instr, // read sysreg onto sr_rd_data
   input  wire logic [4:0]  sr_num,          // system register number
   input  wire logic [31:0] sr_wr_data,      // value for sysreg load
   output logic      [31:0] sr_rd_data,      // value of sysreg store, next cycle
   // events
   input  wire logic        evt_irq,         // exception or maskable interrupt taken
   input  wire logic [15:0] irq_cause_code,  // its cause code
   input  wire logic        evt_nmi,         // non-maskable interrupt taken
   input  wire logic [15:0] nmi_cause_code,  // its cause code
   input  wire logic        evt_tcall,       // table call executed
   input  wire logic        evt_trap,        // illegal instruction trap
   input  wire logic        psw_upd,         // pipeline updates status flags
   input  wire logic [31:0] psw_upd_val,     // new status word
   output logic      [31:0] program_status_word, // current status
   output logic      [31:0] table_call_base      // table call base pointer
);

   // ==========================================================
   // general registers
   gpr_if gb ();

   // short forms read the element base pointer instead of the given index
   always_comb begin
      gb.ra_addr = short_mem_sel ? ELEMENT_BASE_PTR_IDX : gpr_ra_addr; // RL3
      gb.rb_addr = gpr_rb_addr;
      gb.wr_en   = gpr_wr_en;
      gb.wr_addr = gpr_wr_addr;
      gb.wr_data = gpr_wr_data;
   end

   gpr_bank #(
      .DEPTH (GPR_COUNT)                           // RL1
   ) u_gpr (
      .clock   (clock),
      .sys_rst (sys_rst),
      .bus     (gb)
   );

   assign gpr_ra_data = gb.ra_data;
   assign gpr_rb_data = gb.rb_data;

   // ==========================================================
   // helpers
   function automatic logic [31:0] pc_clean(input logic [31:0] v);
      pc_clean = v & PC_MASK; // RL4 RL6 RL17
   endfunction

   // ==========================================================
   // system registers
   // saved pairs
   logic [31:0] irq_pc_q;
   logic [31:0] irq_pc_d;
   logic [31:0] irq_st_q;
   logic [31:0] irq_st_d;
   logic [31:0] nmi_pc_q;
   logic [31:0] nmi_pc_d;
   logic [31:0] nmi_st_q;
   logic [31:0] nmi_st_d;
   logic [31:0] tc_pc_q;
   logic [31:0] tc_pc_d;
   logic [31:0] tc_st_q;
   logic [31:0] tc_st_d;
   logic [31:0] trap_pc_q;
   logic [31:0] trap_pc_d;
   logic [31:0] trap_st_q;
   logic [31:0] trap_st_d;

   // cause, status and call base
   logic [31:0] cause_q;
   logic [31:0] cause_d;
   logic [31:0] psw_q;
   logic [31:0] psw_d;
   logic [31:0] tcb_q;
   logic [31:0] tcb_d;

   // pc and read data
   logic [31:0] pc_q;
   logic [31:0] pc_d;
   logic [31:0] srd_q;
   logic [31:0] srd_d;

   // load strobe alias
   logic        ld;

   assign ld = sysreg_load_instr;

   // saved pairs: an event wins over a software load in the same cycle
   always_comb begin
      irq_pc_d  = irq_pc_q;
      irq_st_d  = irq_st_q;
      nmi_pc_d  = nmi_pc_q;
      nmi_st_d  = nmi_st_q;
      tc_pc_d   = tc_pc_q;
      tc_st_d   = tc_st_q;
      trap_pc_d = trap_pc_q;
      trap_st_d = trap_st_q;
      // trap pair has no load path, so software cannot fake a trap record
      if (ld) begin                                          // RL7
         unique case (sr_num)
            SR_IRQ_SAVED_PC:       irq_pc_d = sr_wr_data;
            SR_IRQ_SAVED_STATUS:   irq_st_d = sr_wr_data;
            SR_NMI_SAVED_PC:       nmi_pc_d = sr_wr_data;
            SR_NMI_SAVED_STATUS:   nmi_st_d = sr_wr_data;
            SR_TCALL_SAVED_PC:     tc_pc_d  = sr_wr_data;
            SR_TCALL_SAVED_STATUS: tc_st_d  = sr_wr_data;
            default: ;  // trap pair and other numbers: dropped, RL13
         endcase
      end
      // event saves use the status value before this cycle's update
      if (evt_irq) begin
         irq_pc_d = pc_q;                                    // RL8
         irq_st_d = psw_q;                                   // RL8
      end
      if (evt_nmi) begin
         nmi_pc_d = pc_q;                                    // RL9
         nmi_st_d = psw_q;                                   // RL9
      end
      if (evt_tcall) begin
         tc_pc_d = pc_q;                                     // RL12
         tc_st_d = psw_q;                                    // RL12
      end
      if (evt_trap) begin
         trap_pc_d = pc_q;                                   // RL13
         trap_st_d = psw_q;                                  // RL13
      end
   end

   // ==========================================================
   // cause, status word and call base
   always_comb begin
      cause_d = cause_q;
      psw_d   = psw_q;
      tcb_d   = tcb_q;
      if (ld) begin                                          // RL7
         unique case (sr_num)
            SR_PROGRAM_STATUS:  psw_d = sr_wr_data;          // RL11
            SR_TABLE_CALL_BASE: tcb_d = sr_wr_data;          // RL14
            default: ;  // cause and reserved numbers: dropped, RL10 RL15
         endcase
      end
      // the pipeline's own flag update beats a software load
      if (psw_upd) begin
         psw_d = psw_upd_val;
      end
      // each event writes only its own half of the cause word
      if (evt_irq) begin
         cause_d[CAUSE_HALF_W-1:0] = irq_cause_code;         // RL10
      end
      if (evt_nmi) begin
         cause_d[DATA_W-1:CAUSE_HALF_W] = nmi_cause_code;    // RL10
      end
   end

   // ==========================================================
   // program counter next value
   always_comb begin
      pc_d = pc_q;
      if (ret_nmi) begin
         pc_d = pc_clean(nmi_pc_q);                          // RL17
      end else if (ret_irq) begin
         pc_d = pc_clean(irq_pc_q);                          // RL17
      end else if (ret_tcall) begin
         pc_d = pc_clean(tc_pc_q);                           // RL17
      end else if (pc_load) begin
         pc_d = pc_clean(pc_target);                         // RL6
      end else if (pc_step) begin
         // sum wraps inside 26 bits since the mask drops the carry
         pc_d = pc_clean(pc_q + {29'h0, pc_step_size});      // RL5
      end
   end

   // ==========================================================
   // read mux for sysreg store; reserved numbers read zero
   always_comb begin
      srd_d = srd_q;
      if (sysreg_store_instr) begin                          // RL7
         unique case (sr_num)
            SR_IRQ_SAVED_PC:       srd_d = irq_pc_q;
            SR_IRQ_SAVED_STATUS:   srd_d = irq_st_q;
            SR_NMI_SAVED_PC:       srd_d = nmi_pc_q;
            SR_NMI_SAVED_STATUS:   srd_d = nmi_st_q;
            SR_EXCEPTION_CAUSE:    srd_d = cause_q;          // RL10
            SR_PROGRAM_STATUS:     srd_d = psw_q;
            SR_TCALL_SAVED_PC:     srd_d = tc_pc_q;
            SR_TCALL_SAVED_STATUS: srd_d = tc_st_q;
            SR_TRAP_SAVED_PC:      srd_d = trap_pc_q;
            SR_TRAP_SAVED_STATUS:  srd_d = trap_st_q;
            SR_TABLE_CALL_BASE:    srd_d = tcb_q;
            default:               srd_d = REG_RESET;        // RL15
         endcase
      end
   end

   // ==========================================================
   // saved pairs, all 32 bits wide
   always_ff @(posedge clock or posedge sys_rst) begin       // RL16
      if (sys_rst) begin
         irq_pc_q  <= REG_RESET;
         irq_st_q  <= REG_RESET;
         nmi_pc_q  <= REG_RESET;
         nmi_st_q  <= REG_RESET;
         tc_pc_q   <= REG_RESET;
         tc_st_q   <= REG_RESET;
         trap_pc_q <= REG_RESET;
         trap_st_q <= REG_RESET;
      end else begin
         irq_pc_q  <= irq_pc_d;
         irq_st_q  <= irq_st_d;
         nmi_pc_q  <= nmi_pc_d;
         nmi_st_q  <= nmi_st_d;
         tc_pc_q   <= tc_pc_d;
         tc_st_q   <= tc_st_d;
         trap_pc_q <= trap_pc_d;
         trap_st_q <= trap_st_d;
      end
   end

   // ==========================================================
   // cause, status word and call base registers
   always_ff @(posedge clock or posedge sys_rst) begin       // RL16
      if (sys_rst) begin
         cause_q <= REG_RESET;
         psw_q   <= REG_RESET;
         tcb_q   <= REG_RESET;
      end else begin
         cause_q <= cause_d;
         psw_q   <= psw_d;
         tcb_q   <= tcb_d;
      end
   end

   // ==========================================================
   // program counter; reset value is already even and in range
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pc_q <= PC_RESET;
      end else begin
         pc_q <= pc_d;
      end
   end

   // ==========================================================
   // store read data; holds until the next store
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         srd_q <= REG_RESET;
      end else begin
         srd_q <= srd_d;
      end
   end

   // outputs come straight from the registers
   assign pc                  = pc_q;
   assign sr_rd_data          = srd_q;
   assign program_status_word = psw_q;
   assign table_call_base     = tcb_q;
endmodule // cpu_register_file

// ==== cpu_register_file_sva.sv ====
// checker: port-level assertions for the cpu register file
`timescale 1ns/10ps
module cpu_register_file_sva
   import cpu_regs_pkg::*;
(
   input wire logic        clock,               // core clock
   input wire logic        sys_rst,             // async reset
   input wire logic [4:0]  gpr_ra_addr,         // port a index
   input wire logic [4:0]  gpr_rb_addr,         // port b index
   input wire logic        short_mem_sel,       // base select
   input wire logic [31:0] gpr_ra_data,         // port a data
   input wire logic [31:0] gpr_rb_data,         // port b data
   input wire logic        pc_load,             // pc load
   input wire logic [31:0] pc_target,           // pc target
   input wire logic        pc_step,             // pc advance
   input wire logic [2:0]  pc_step_size,        // advance size
   input wire logic        ret_irq,             // irq return
   input wire logic        ret_nmi,             // nmi return
   input wire logic        ret_tcall,           // tcall return
   input wire logic [31:0] pc,                  // program counter
   input wire logic        sysreg_load_instr,   // sysreg write
   input wire logic        sysreg_store_instr,  // sysreg read
   input wire logic [4:0]  sr_num,              // sysreg number
   input wire logic [31:0] sr_wr_data,          // sysreg wdata
   input wire logic [31:0] sr_rd_data,          // sysreg rdata
   input wire logic        evt_irq,             // irq taken
   input wire logic        psw_upd,             // status update
   input wire logic [31:0] psw_upd_val,         // update value
   input wire logic [31:0] program_status_word, // status
   input wire logic [31:0] table_call_base      // call base
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   // no return pending: lower-priority pc sources are then in charge
   wire no_ret = !ret_irq && !ret_nmi && !ret_tcall;
   // multi-step behaviours
   sequence s_irq_taken; evt_irq; endsequence
   sequence s_irq_pc_read;
      sysreg_store_instr && sr_num == SR_IRQ_SAVED_PC && !evt_irq && !sysreg_load_instr;
   endsequence
   sequence s_irq_pc_set; sysreg_load_instr && sr_num == SR_IRQ_SAVED_PC && !evt_irq; endsequence
   sequence s_quiet; !(sysreg_load_instr && sr_num == SR_IRQ_SAVED_PC) && !evt_irq; endsequence
   AST_ZERO_RA: assert property (gpr_ra_addr == ZERO_REG_IDX && !short_mem_sel |=> gpr_ra_data == 0)
      else $error("port a read of zero register not zero");
   AST_ZERO_RB: assert property (gpr_rb_addr == ZERO_REG_IDX |=> gpr_rb_data == 0)
      else $error("port b read of zero register not zero");
   AST_PC_RANGE: assert property ((pc & ~PC_MASK) == 0)
      else $error("pc has bits outside the valid range");
   AST_PC_STEP: assert property (pc_step && !pc_load && no_ret |=>
      pc == (($past(pc) + 32'($past(pc_step_size))) & PC_MASK))
      else $error("pc advance wrong");
   AST_PC_LOAD: assert property (pc_load && no_ret |=> pc == ($past(pc_target) & PC_MASK))
      else $error("pc load wrong");
   AST_TCB_LOAD: assert property (sysreg_load_instr && sr_num == SR_TABLE_CALL_BASE |=>
      table_call_base == $past(sr_wr_data))
      else $error("call base write lost");
   AST_STATUS_LOAD: assert property (sysreg_load_instr && sr_num == SR_PROGRAM_STATUS && !psw_upd |=>
      program_status_word == $past(sr_wr_data))
      else $error("status word write lost");
   AST_STATUS_UPD: assert property (psw_upd |=>
      program_status_word == $past(psw_upd_val))
      else $error("status word update lost");
   AST_IRQ_SAVE: assert property (s_irq_taken ##1 s_irq_pc_read |=>
      sr_rd_data == $past(pc, 2))
      else $error("irq saved pc differs from pc at the event");
   AST_RET_IRQ: assert property (s_irq_pc_set ##1 s_quiet ##1 (ret_irq && !ret_nmi) |=>
      pc == ($past(sr_wr_data, 3) & PC_MASK))
      else $error("return pc not taken from saved value");
endmodule // cpu_register_file_sva
bind cpu_register_file cpu_register_file_sva sva_u (.clock, .sys_rst, .gpr_ra_addr,
   .gpr_rb_addr, .short_mem_sel, .gpr_ra_data, .gpr_rb_data, .pc_load, .pc_target, .pc_step,
   .pc_step_size, .ret_irq, .ret_nmi, .ret_tcall, .pc, .sysreg_load_instr, .sysreg_store_instr,
   .sr_num, .sr_wr_data, .sr_rd_data, .evt_irq, .psw_upd, .psw_upd_val, .program_status_word,
   .table_call_base);

// ==== pipe_model.sv ====
// partner: pipeline side issuing system register load and store instructions
`timescale 1ns/10ps
module pipe_model (
   input  wire logic  clock,              // core clock
   output logic       sysreg_load_instr,  // load pulse
   output logic       sysreg_store_instr, // store pulse
   output logic [4:0] sr_num,             // register number
   output logic [31:0] sr_wr_data         // load value
);
   // idle at time zero
   initial begin
      {sysreg_load_instr, sysreg_store_instr, sr_num, sr_wr_data} = '0;
   end
   // called at a falling edge; idle cycle after keeps pulses apart
   task automatic sr_write(input logic [4:0] n, input logic [31:0] d);
      {sysreg_load_instr, sr_num, sr_wr_data} = {1'b1, n, d};
      @(negedge clock);
      {sysreg_load_instr, sr_wr_data} = {1'b0, ~d}; // stale data must not look valid
      @(negedge clock);
   endtask
   // only documented numbers are ever asked for by the bench
   task automatic sr_read(input logic [4:0] n);
      {sysreg_store_instr, sr_num} = {1'b1, n};
      @(negedge clock);
      sysreg_store_instr = 1'b0;
      @(negedge clock);
   endtask
endmodule // pipe_model

// ==== cpu_register_file_tb_top.sv ====
// testbench: self-checking bench of the cpu register file
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module cpu_register_file_tb_top;
   import cpu_regs_pkg::*;
   typedef struct {logic [4:0] n; logic [31:0] w; logic [31:0] e;} row_t;
   logic clock, sys_rst, short_mem_sel, gpr_wr_en, pc_load, pc_step, ret_irq;
   logic ret_nmi, ret_tcall, psw_upd;
   logic evt_irq, evt_nmi, evt_tcall, evt_trap, sysreg_load_instr, sysreg_store_instr;
   logic [4:0]  gpr_ra_addr, gpr_rb_addr, gpr_wr_addr, sr_num;
   logic [31:0] gpr_wr_data, pc_target, sr_wr_data, gpr_ra_data, gpr_rb_data, pc, sr_rd_data;
   logic [31:0] status_word, call_base, psw_val;
   logic [2:0]  pc_step_size;
   logic [15:0] irq_cc, nmi_cc;
   int n_fail = 0, n_tests = 0, cycles = 0;
   // sysreg number, value loaded, value read back (read-only ones keep zero)
   row_t rows[11] = '{'{5'h00, 32'h1235, 32'h1235}, '{5'h01, 32'h11, 32'h11},
      '{5'h02, 32'h22, 32'h22}, '{5'h03, 32'h33, 32'h33}, '{5'h04, 32'hffff_ffff, 32'h0},
      '{5'h05, 32'ha5, 32'ha5}, '{5'h10, 32'h1000, 32'h1000}, '{5'h11, 32'h44, 32'h44},
      '{5'h12, 32'hffff_ffff, 32'h0}, '{5'h13, 32'hffff_ffff, 32'h0},
      '{5'h14, 32'h0abc_def0, 32'h0abc_def0}};
   logic [4:0]  ev[9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h10, 5'h11, 5'h12, 5'h13};
   cpu_register_file dut_u (.clock, .sys_rst, .gpr_ra_addr, .gpr_rb_addr, .short_mem_sel,
      .gpr_ra_data, .gpr_rb_data, .gpr_wr_en, .gpr_wr_addr, .gpr_wr_data, .pc_load, .pc_target,
      .pc_step, .pc_step_size, .ret_irq, .ret_nmi, .ret_tcall, .pc,
      .sysreg_load_instr, .sysreg_store_instr, .sr_num, .sr_wr_data, .sr_rd_data, .evt_irq,
      .irq_cause_code(irq_cc), .evt_nmi, .nmi_cause_code(nmi_cc), .evt_tcall, .evt_trap,
      .psw_upd, .psw_upd_val(psw_val), .program_status_word(status_word),
      .table_call_base(call_base));
   pipe_model pm_u (.clock, .sysreg_load_instr, .sysreg_store_instr, .sr_num, .sr_wr_data);
   // ==========================================
   // clock and hang guard
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic final_report();
      if (n_fail == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ==========================================
   // main sequence, inputs move at falling edges
   initial begin
      {short_mem_sel, gpr_wr_en, pc_load, pc_step, ret_irq, evt_irq, evt_nmi} = '0;
      {evt_tcall, evt_trap, gpr_ra_addr, gpr_rb_addr, gpr_wr_addr, gpr_wr_data} = '0;
      {pc_target, pc_step_size, irq_cc, nmi_cc} = '0;
      {ret_nmi, ret_tcall, psw_upd, psw_val} = '0;
      sys_rst = 1'b1;
      repeat (12) @(negedge clock);
      sys_rst = 1'b0;
      @(negedge clock);
      `CHK("pc", 32'h0, pc)
      foreach (rows[i]) begin
         pm_u.sr_write(rows[i].n, rows[i].w);
         pm_u.sr_read(rows[i].n);
         `CHK("sysreg", rows[i].e, sr_rd_data)
      end
      `CHK("status", 32'ha5, status_word)
      `CHK("call base", 32'h0abc_def0, call_base)
      // general registers: back-to-back writes, zero index, implicit base
      {gpr_wr_en, gpr_wr_addr, gpr_wr_data} = {1'b1, 5'h03, 32'h1234_5678};
      @(negedge clock);
      {gpr_wr_en, gpr_wr_addr, gpr_wr_data} = {1'b1, 5'h00, 32'hffff_ffff};
      {gpr_ra_addr, gpr_rb_addr} = {5'h03, 5'h00};
      @(negedge clock);
      `CHK("gpr a", 32'h1234_5678, gpr_ra_data)
      `CHK("gpr b", 32'h0, gpr_rb_data)
      {gpr_wr_en, gpr_wr_addr, gpr_wr_data} = {1'b1, 5'h1e, 32'h0000_0bee};
      @(negedge clock);
      `CHK("gpr zero", 32'h0, gpr_rb_data)
      {gpr_wr_en, short_mem_sel, gpr_ra_addr} = {1'b0, 1'b1, 5'h00};
      @(negedge clock);
      `CHK("base", 32'h0000_0bee, gpr_ra_data)
      short_mem_sel = 1'b0;
      // pc masking and wrap past bit 25
      {pc_load, pc_target} = {1'b1, 32'hffff_ffff};
      @(negedge clock);
      `CHK("pc load", 32'h03ff_fffe, pc)
      {pc_load, pc_step, pc_step_size} = {1'b0, 1'b1, 3'h4};
      @(negedge clock);
      `CHK("pc wrap", 32'h2, pc)
      pc_step = 1'b0;
      // all four events in one cycle, each saves into its own pair
      {evt_irq, evt_nmi, evt_tcall, evt_trap, irq_cc, nmi_cc} = {4'hf, 16'h1234, 16'habcd};
      @(negedge clock);
      {evt_irq, evt_nmi, evt_tcall, evt_trap} = 4'h0;
      foreach (ev[i]) begin
         pm_u.sr_read(ev[i]);
         `CHK("saved", ev[i] == 5'h04 ? 32'habcd_1234 : (ev[i][0] ? 32'ha5 : 32'h2), sr_rd_data)
      end
      // read-only registers ignore loads
      pm_u.sr_write(SR_TRAP_SAVED_PC, 32'h0);
      pm_u.sr_read(SR_TRAP_SAVED_PC);
      `CHK("trap pc", 32'h2, sr_rd_data)
      pm_u.sr_write(SR_EXCEPTION_CAUSE, 32'h0);
      pm_u.sr_read(SR_EXCEPTION_CAUSE);
      `CHK("cause", 32'habcd_1234, sr_rd_data)
      // return through an odd saved pc
      pm_u.sr_write(SR_IRQ_SAVED_PC, 32'h0000_1235);
      ret_irq = 1'b1;
      @(negedge clock);
      ret_irq = 1'b0;
      `CHK("ret pc", 32'h0000_1234, pc)
      // nmi return wins over an irq return in the same cycle
      pm_u.sr_write(SR_NMI_SAVED_PC, 32'h0000_0101);
      {ret_nmi, ret_irq} = 2'b11;
      @(negedge clock);
      {ret_nmi, ret_irq} = 2'b00;
      `CHK("ret nmi", 32'h0000_0100, pc)
      pm_u.sr_write(SR_TCALL_SAVED_PC, 32'h0000_0203);
      ret_tcall = 1'b1;
      @(negedge clock);
      ret_tcall = 1'b0;
      `CHK("ret tcall", 32'h0000_0202, pc)
      // pipeline flag update beats a software load in the same cycle
      {psw_upd, psw_val} = {1'b1, 32'h0000_0077};
      fork
         pm_u.sr_write(SR_PROGRAM_STATUS, 32'h0000_005a);
         begin
            @(negedge clock);
            psw_upd = 1'b0;
         end
      join
      `CHK("status upd", 32'h0000_0077, status_word)
      // mid-run reset clears all state; port a points at a written register
      gpr_ra_addr = 5'h03;
      sys_rst = 1'b1;
      @(negedge clock);
      `CHK("rst pc", 32'h0, pc)
      sys_rst = 1'b0;
      @(negedge clock);
      `CHK("rst status", 32'h0, status_word)
      `CHK("rst base", 32'h0, call_base)
      `CHK("rst sysreg", 32'h0, sr_rd_data)
      `CHK("rst gpr", 32'h0, gpr_ra_data)
      final_report();
   end
endmodule // cpu_register_file_tb_top
